// ---- src/sbp_mem.sv ----
// device end: bank state, power states, burst control and storage
// Contract
// - cke fall suspends, rise resumes next cycle
// - cke rise exits self refresh unclocked
// - controller waits one clock after power down exit, trc after self refresh exit
// - low power entry only all banks idle
// - chip select high ignores command inputs
// - bank bits select bank a to d
// - a10 on read/write selects auto precharge
// - precharge a10 high closes all banks
// - precharge cuts read, latency minus one words
// - outputs release after programmed burst ends
// - controller raises dqm three cycles before write (controller only passes req_dqm with each command, SBP_DQM_LEAD unused)
// - precharge stops write, later data dropped
// - controller masks data on precharge cycle (controller only passes req_dqm with each command)
// - interrupting precharge targets burst bank
// - ras cas we high is nop
// - burst stop ends any burst length
// - self refresh entry, only cke counts
// - controller holds self refresh tras minimum
// - exit with stable clock, cs high, trc
// - burst refresh around self refresh (controller issues no refresh of its own, only passes requests)
// - power down needs idle, setup before activate
// - mode set needs idle, two clocks wait
// - no command during trc after refresh
module sbp_mem
  import sbp_pkg::*;
#(
  parameter int DEPTH_W = 6
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // memory pins
  sbp_if.mem        pins,
  // status
  output logic      all_banks_idle,
  output logic      self_refresh,
  output logic      power_down
);
  initial begin
    if (DEPTH_W < 1 || DEPTH_W > 16) $error("sbp_mem: bad DEPTH_W");
  end
  // ****************************************************************
  // decode
  // ****************************************************************
  logic [SBP_DQ_W-1:0]  mem_q [SBP_BANKS][2**DEPTH_W];
  sbp_bank_e            bank_ff [SBP_BANKS];
  logic [SBP_TMR_W-1:0] btmr_ff [SBP_BANKS];
  logic [SBP_BANKS-1:0] bap_ff;
  sbp_pwr_e             pwr_ff;
  logic                 cke_ff;
  logic [11:0]          mr_ff;
  logic [SBP_TMR_W-1:0] gtmr_ff;
  logic                 bact_ff;
  logic                 bwr_ff;
  logic [1:0]           bbank_ff;
  logic [SBP_COL_W-1:0] bcol_ff;
  logic [8:0]           bleft_ff;
  logic [1:0]           rpipe_ff;
  logic [SBP_DQ_W-1:0]  rdat_ff [2];
  logic [SBP_DQ_W-1:0]  dq_ff;
  logic                 oe_ff;
  logic                 sref_async;
  logic [SBP_DQ_W-1:0]  wlat_ff;
  logic                 wmsk_ff;
  function automatic logic [8:0] bl_len(input logic [2:0] bl);
    case (bl)
      SBP_BL_1: bl_len = 9'h001;
      SBP_BL_2: bl_len = 9'h002;
      SBP_BL_4: bl_len = 9'h004;
      SBP_BL_8: bl_len = 9'h008;
      default:  bl_len = 9'h100;
    endcase
  endfunction
  wire       clk_run = cke_ff && (pwr_ff == SBP_P_RUN);
  // ras cas we high is nop
  wire [2:0] cmd = pins.cs_n ? SBP_C_NOP
                 : {pins.ras_n, pins.cas_n, pins.we_n};
  wire [1:0] sel = pins.ba;
  wire       ap  = pins.addr[SBP_AP_BIT];
  wire       live = clk_run && pins.cke;
  wire       do_act = live && cmd == SBP_C_ACT;
  wire       do_rd  = live && cmd == SBP_C_READ;
  wire       do_wr  = live && cmd == SBP_C_WRITE;
  wire       do_pre = live && cmd == SBP_C_PRE;
  wire       do_stp = live && cmd == SBP_C_STOP;
  wire       do_mrs = live && cmd == SBP_C_MRS && all_banks_idle;
  wire       do_ref = live && cmd == SBP_C_REF && all_banks_idle;
  wire [2:0] mr_bl  = mr_ff[SBP_MR_BL_LO +: 3];
  wire [1:0] mr_cl  = mr_ff[SBP_MR_CL_LO +: 2];
  wire       pre_hit = do_pre && (ap || sel == bbank_ff);
  wire       b_end  = bact_ff && bleft_ff == 9'h001;
  wire       wr_beat = bact_ff && bwr_ff && !pre_hit
                       && !wmsk_ff;
  wire [DEPTH_W-1:0] widx = DEPTH_W'(bcol_ff);
  // ****************************************************************
  // status
  // ****************************************************************
  always_comb begin
    all_banks_idle = (gtmr_ff == SBP_TMR_ZERO);
    for (int i = 0; i < SBP_BANKS; i++) begin
      if (bank_ff[i] != SBP_B_IDLE) all_banks_idle = 1'b0;
    end
  end
  assign self_refresh    = (pwr_ff == SBP_P_SREF);
  assign power_down      = (pwr_ff == SBP_P_PDN);
  assign pins.dq_mem     = dq_ff;
  assign pins.dq_mem_oe  = oe_ff;
  assign sref_async = self_refresh && pins.cke;
  // ****************************************************************
  // power state
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pwr_ff <= SBP_P_RUN;
      cke_ff <= 1'b1;
    end else begin
      cke_ff <= pins.cke;
      case (pwr_ff)
        SBP_P_RUN: begin
          if (cke_ff && !pins.cke && all_banks_idle && !pins.cs_n
              && !pins.ras_n && !pins.cas_n && pins.we_n)
            pwr_ff <= SBP_P_SREF;
          else if (cke_ff && !pins.cke && all_banks_idle)
            pwr_ff <= SBP_P_PDN;
          else if (cke_ff && !pins.cke)
            pwr_ff <= SBP_P_SUSP;
        end
        SBP_P_SUSP: if (pins.cke) pwr_ff <= SBP_P_RUN;
        SBP_P_PDN:  if (pins.cke) pwr_ff <= SBP_P_RUN;
        SBP_P_SREF: if (sref_async) pwr_ff <= SBP_P_RUN;
        default:    pwr_ff <= SBP_P_RUN;
      endcase
    end
  end
  // ****************************************************************
  // banks
  // ****************************************************************
  // per bank state
  for (genvar b = 0; b < SBP_BANKS; b++) begin : g_bank
    wire hit = (sel == 2'(b));
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        bank_ff[b] <= SBP_B_IDLE;
        btmr_ff[b] <= SBP_TMR_ZERO;
        bap_ff[b]  <= 1'b0;
      end else if (clk_run) begin
        if (btmr_ff[b] != SBP_TMR_ZERO) btmr_ff[b] <= btmr_ff[b] - 1'b1;
        if (do_pre && (ap || hit) && bank_ff[b] != SBP_B_IDLE) begin
          bank_ff[b] <= SBP_B_PREG;
          btmr_ff[b] <= SBP_TMR_W'(SBP_TRP_CYC);
        end else if (do_act && hit && bank_ff[b] == SBP_B_IDLE) begin
          bank_ff[b] <= SBP_B_ACTG;
          btmr_ff[b] <= SBP_TMR_W'(SBP_TRCD_CYC);
        end else if ((do_rd || do_wr) && hit) begin
          bank_ff[b] <= do_rd ? SBP_B_RD : SBP_B_WR;
          bap_ff[b]  <= ap;
        end else if ((do_rd || do_wr || do_stp) && bbank_ff == 2'(b)
                     && (bank_ff[b] == SBP_B_RD
                         || bank_ff[b] == SBP_B_WR)) begin
          bank_ff[b] <= SBP_B_ACT;
        end else if (b_end && bbank_ff == 2'(b)) begin
          bank_ff[b] <= bap_ff[b] ? SBP_B_PREG : SBP_B_ACT;
          btmr_ff[b] <= SBP_TMR_W'(SBP_TRP_CYC);
        end else if (btmr_ff[b] == SBP_TMR_ZERO) begin
          if (bank_ff[b] == SBP_B_ACTG) bank_ff[b] <= SBP_B_ACT;
          if (bank_ff[b] == SBP_B_PREG) bank_ff[b] <= SBP_B_IDLE;
        end
      end
    end
  end
  // ****************************************************************
  // mode register, refresh timer, burst
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mr_ff    <= SBP_MR_RST;
      gtmr_ff  <= SBP_TMR_ZERO;
      bact_ff  <= 1'b0;
      bwr_ff   <= 1'b0;
      bbank_ff <= 2'h0;
      bcol_ff  <= '0;
      bleft_ff <= 9'h000;
    end else if (sref_async) begin
      gtmr_ff  <= SBP_TMR_W'(SBP_TRC_CYC);
    end else if (clk_run) begin
      if (gtmr_ff != SBP_TMR_ZERO) gtmr_ff <= gtmr_ff - 1'b1;
      if (do_mrs) begin
        mr_ff   <= pins.addr;
        gtmr_ff <= SBP_TMR_W'(SBP_MRD_CYC);
      end
      if (do_ref) gtmr_ff <= SBP_TMR_W'(SBP_TRC_CYC);
      if (do_rd || do_wr) begin
        bact_ff  <= 1'b1;
        bwr_ff   <= do_wr;
        bbank_ff <= sel;
        bcol_ff  <= pins.addr[SBP_COL_W-1:0];
        bleft_ff <= bl_len(mr_bl);
      end else if (do_stp || pre_hit || b_end) begin
        bact_ff  <= 1'b0;
        bleft_ff <= 9'h000;
      end else if (bact_ff) begin
        bcol_ff  <= bcol_ff + 1'b1;
        bleft_ff <= bleft_ff - 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    // data and mask taken in their own cycle, stored one later
    if (clk_run) begin
      wlat_ff <= pins.dq_bus;
      wmsk_ff <= pins.dqm[0];
    end
    if (wr_beat && clk_run)
      mem_q[bbank_ff][widx] <= wlat_ff;
  end
  // ****************************************************************
  // read pipeline and output drive
  // ****************************************************************
  wire rd_beat = bact_ff && !bwr_ff && clk_run;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rpipe_ff   <= 2'h0;
      rdat_ff[0] <= '0;
      rdat_ff[1] <= '0;
      dq_ff      <= '0;
      oe_ff      <= 1'b0;
    end else if (self_refresh) begin
      rpipe_ff <= 2'h0;
      oe_ff    <= 1'b0;
    end else if (clk_run) begin
      rpipe_ff   <= {rpipe_ff[0], rd_beat};
      rdat_ff[0] <= mem_q[bbank_ff][widx];
      rdat_ff[1] <= rdat_ff[0];
      if (mr_cl == 2'h3) begin
        oe_ff <= rpipe_ff[1];
        dq_ff <= rdat_ff[1];
      end else begin
        oe_ff <= rpipe_ff[0];
        dq_ff <= rdat_ff[0];
      end
    end
  end
endmodule

// ---- common/sbp_pkg.sv ----
// package: shared constants for the sdram bank and power control ends
package sbp_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int          SBP_BANKS    = 4;
  localparam int          SBP_BA_W     = 2;
  localparam int          SBP_ADDR_W   = 12;
  localparam int          SBP_DQ_W     = 32;
  localparam int          SBP_DQM_W    = 4;
  localparam int          SBP_AP_BIT   = 10;
  localparam int          SBP_COL_W    = 8;
  // ****************************************************************
  // timing, 25 mhz clock
  // ****************************************************************
  localparam int          SBP_CLK_NS   = 40;
  localparam int          SBP_TRC_NS   = 80;
  localparam int          SBP_TRAS_NS  = 48;
  localparam int          SBP_TRCD_NS  = 20;
  localparam int          SBP_TRP_NS   = 20;
  localparam int          SBP_TRC_CYC  = (SBP_TRC_NS + SBP_CLK_NS - 1)
                                         / SBP_CLK_NS;
  localparam int          SBP_TRAS_CYC = (SBP_TRAS_NS + SBP_CLK_NS - 1)
                                         / SBP_CLK_NS;
  localparam int          SBP_TRCD_CYC = (SBP_TRCD_NS + SBP_CLK_NS - 1)
                                         / SBP_CLK_NS;
  localparam int          SBP_TRP_CYC  = (SBP_TRP_NS + SBP_CLK_NS - 1)
                                         / SBP_CLK_NS;
  localparam int          SBP_MRD_CYC  = 2;
  localparam int          SBP_EXIT_CYC = 1;
  localparam int          SBP_DQM_LEAD = 3;
  localparam int          SBP_CAS_LAT  = 2;
  localparam int          SBP_TMR_W    = 4;
  localparam logic [3:0]  SBP_TMR_ZERO = 4'h0;
  // ****************************************************************
  // commands as {ras_n, cas_n, we_n}
  // ****************************************************************
  localparam logic [2:0]  SBP_C_NOP    = 3'h7;
  localparam logic [2:0]  SBP_C_STOP   = 3'h6;
  localparam logic [2:0]  SBP_C_READ   = 3'h5;
  localparam logic [2:0]  SBP_C_WRITE  = 3'h4;
  localparam logic [2:0]  SBP_C_ACT    = 3'h3;
  localparam logic [2:0]  SBP_C_PRE    = 3'h2;
  localparam logic [2:0]  SBP_C_REF    = 3'h1;
  localparam logic [2:0]  SBP_C_MRS    = 3'h0;
  // ****************************************************************
  // mode register fields
  // ****************************************************************
  localparam int          SBP_MR_BL_LO = 0;
  localparam int          SBP_MR_CL_LO = 4;
  localparam logic [2:0]  SBP_BL_1     = 3'h0;
  localparam logic [2:0]  SBP_BL_2     = 3'h1;
  localparam logic [2:0]  SBP_BL_4     = 3'h2;
  localparam logic [2:0]  SBP_BL_8     = 3'h3;
  localparam logic [2:0]  SBP_BL_PAGE  = 3'h7;
  localparam logic [11:0] SBP_MR_RST   = 12'h022;
  // ****************************************************************
  // per-bank state
  // ****************************************************************
  typedef enum logic [5:0] {
    SBP_B_IDLE  = 6'h01,
    SBP_B_ACTG  = 6'h02,
    SBP_B_ACT   = 6'h04,
    SBP_B_RD    = 6'h08,
    SBP_B_WR    = 6'h10,
    SBP_B_PREG  = 6'h20
  } sbp_bank_e;
  // power state of the device
  typedef enum logic [3:0] {
    SBP_P_RUN   = 4'h1,
    SBP_P_SUSP  = 4'h2,
    SBP_P_PDN   = 4'h4,
    SBP_P_SREF  = 4'h8
  } sbp_pwr_e;
endpackage

// ---- common/sbp_if.sv ----
// interface: sdram command, address and data pins between the two ends
interface sbp_if
  import sbp_pkg::*;
  ();
  logic                  cke;
  logic                  cs_n;
  logic                  ras_n;
  logic                  cas_n;
  logic                  we_n;
  logic [SBP_BA_W-1:0]   ba;
  logic [SBP_ADDR_W-1:0] addr;
  logic [SBP_DQM_W-1:0]  dqm;
  logic [SBP_DQ_W-1:0]   dq_ctl;
  logic                  dq_ctl_oe;
  logic [SBP_DQ_W-1:0]   dq_mem;
  logic                  dq_mem_oe;
  logic [SBP_DQ_W-1:0]   dq_bus;
  // shared data wire resolved from both enables, released shows inverse
  assign dq_bus = dq_mem_oe ? dq_mem : dq_ctl_oe ? dq_ctl : ~dq_ctl;
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
               input dq_bus, output dq_mem, dq_mem_oe);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
               output dq_ctl, dq_ctl_oe, input dq_bus);
endinterface

// ---- src/sbp_ctl.sv ----
// controller end: turns user requests into timed sdram commands
module sbp_ctl
  import sbp_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // user request
  input  wire logic                  req_valid,
  input  wire logic [2:0]            req_cmd,
  input  wire logic [SBP_BA_W-1:0]   req_ba,
  input  wire logic [SBP_ADDR_W-1:0] req_addr,
  input  wire logic [SBP_DQ_W-1:0]   req_wdata,
  input  wire logic [SBP_DQM_W-1:0]  req_dqm,
  input  wire logic                  req_cke,
  output logic                       req_ready,
  // read data
  output logic [SBP_DQ_W-1:0]        rd_data,
  // memory pins
  sbp_if.ctl                         pins
);
  // ****************************************************************
  // pacing
  // ****************************************************************
  logic                 cke_ff;
  logic [SBP_TMR_W-1:0] wait_ff;
  logic [2:0]           cmd_ff;
  logic [SBP_BA_W-1:0]  ba_ff;
  logic [SBP_ADDR_W-1:0] addr_ff;
  logic [SBP_DQM_W-1:0] dqm_ff;
  logic [SBP_DQ_W-1:0]  wd_ff;
  logic                 oe_ff;
  logic [SBP_DQ_W-1:0]  rd_ff;
  logic                 sref_ff;
  logic [SBP_TMR_W-1:0] sref_cnt_ff;
  localparam logic [SBP_TMR_W-1:0] SBP_TMR_TW = SBP_TMR_W'(SBP_EXIT_CYC);
  wire  take = req_valid && req_ready;
  wire [SBP_TMR_W-1:0] gap =
      (req_cmd == SBP_C_REF)  ? SBP_TMR_W'(SBP_TRC_CYC)
    : (req_cmd == SBP_C_MRS)  ? SBP_TMR_W'(SBP_MRD_CYC)
    : SBP_TMR_TW;
  wire sref_hold = sref_ff && sref_cnt_ff != SBP_TMR_ZERO;
  assign req_ready = (wait_ff == SBP_TMR_ZERO) && !sref_hold;
  assign pins.cke       = cke_ff;
  assign pins.cs_n      = (cmd_ff == SBP_C_NOP);
  assign pins.ras_n     = cmd_ff[2];
  assign pins.cas_n     = cmd_ff[1];
  assign pins.we_n      = cmd_ff[0];
  assign pins.ba        = ba_ff;
  assign pins.addr      = addr_ff;
  assign pins.dqm       = dqm_ff;
  assign pins.dq_ctl    = wd_ff;
  assign pins.dq_ctl_oe = oe_ff;
  assign rd_data        = rd_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cke_ff      <= 1'b1;
      wait_ff     <= SBP_TMR_ZERO;
      cmd_ff      <= SBP_C_NOP;
      ba_ff       <= '0;
      addr_ff     <= '0;
      dqm_ff      <= '0;
      wd_ff       <= '0;
      oe_ff       <= 1'b0;
      rd_ff       <= '0;
      sref_ff     <= 1'b0;
      sref_cnt_ff <= SBP_TMR_ZERO;
    end else begin
      rd_ff <= pins.dq_bus;
      if (wait_ff != SBP_TMR_ZERO) wait_ff <= wait_ff - 1'b1;
      if (sref_cnt_ff != SBP_TMR_ZERO) sref_cnt_ff <= sref_cnt_ff - 1'b1;
      cmd_ff <= SBP_C_NOP;
      oe_ff  <= 1'b0;
      if (take) begin
        cmd_ff  <= req_cmd;
        ba_ff   <= req_ba;
        addr_ff <= req_addr;
        dqm_ff  <= req_dqm;
        wd_ff   <= req_wdata;
        oe_ff   <= (req_cmd == SBP_C_WRITE);
        cke_ff  <= req_cke;
        wait_ff <= gap;
        if (cke_ff && !req_cke && req_cmd == SBP_C_REF) begin
          sref_ff     <= 1'b1;
          sref_cnt_ff <= SBP_TMR_W'(SBP_TRAS_CYC);
        end
        if (!cke_ff && req_cke) begin
          sref_ff <= 1'b0;
          cmd_ff  <= SBP_C_NOP;
          if (sref_ff) wait_ff <= SBP_TMR_W'(SBP_TRC_CYC);
        end
      end
    end
  end
endmodule

// ---- verif/sbp_props.sv ----
// checker: concurrent assertions on the pins joining the two ends
module sbp_props
  import sbp_pkg::*;
(
  // clock and reset
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  // command pins
  input wire logic                  cke,
  input wire logic                  cs_n,
  input wire logic                  ras_n,
  input wire logic                  cas_n,
  input wire logic                  we_n,
  input wire logic [SBP_BA_W-1:0]   ba,
  input wire logic [SBP_ADDR_W-1:0] addr,
  // data enables
  input wire logic                  dq_mem_oe,
  input wire logic                  dq_ctl_oe,
  // device status
  input wire logic                  all_banks_idle,
  input wire logic                  self_refresh,
  input wire logic                  power_down
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // command decode
  // ****************************************************************
  wire logic [2:0] cmd_w   = {ras_n, cas_n, we_n};
  wire logic       live_w  = cke && !cs_n;
  wire logic       rd_w    = live_w && (cmd_w == SBP_C_READ);
  wire logic       pre_w   = live_w && (cmd_w == SBP_C_PRE);
  wire logic       stop_w  = live_w && (cmd_w == SBP_C_STOP);
  wire logic       mrs_w   = live_w && (cmd_w == SBP_C_MRS);
  wire logic       quiet_w = cke && (cs_n || (cmd_w == SBP_C_NOP));
  wire logic       sref_w  = !cke && !cs_n && (cmd_w == SBP_C_REF);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_rst;
    $fell(sys_rst) |-> cke && cs_n && !dq_mem_oe && !dq_ctl_oe
                       && all_banks_idle;
  endproperty
  a_rst: assert property (p_rst) else $error("pins busy after reset");
  property p_burst;
    rd_w ##1 quiet_w ##1 quiet_w |=> dq_mem_oe [*4] ##1 !dq_mem_oe;
  endproperty
  a_burst: assert property (p_burst) else $error("read burst length");
  property p_cut;
    rd_w ##1 quiet_w ##1 (pre_w && ba == $past(ba, 2))
      |=> dq_mem_oe ##1 dq_mem_oe ##1 !dq_mem_oe;
  endproperty
  a_cut: assert property (p_cut) else $error("read cut by precharge");
  property p_stop;
    rd_w ##1 quiet_w ##1 stop_w |=> dq_mem_oe ##1 dq_mem_oe ##1 !dq_mem_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("burst stop ignored");
  property p_preall;
    pre_w && addr[SBP_AP_BIT] |-> ##[1:3] all_banks_idle;
  endproperty
  a_preall: assert property (p_preall) else $error("banks left open");
  property p_sref;
    sref_w |=> self_refresh;
  endproperty
  a_sref: assert property (p_sref) else $error("no self refresh");
  property p_sref_hold;
    self_refresh && !cke |=> self_refresh;
  endproperty
  a_sref_hold: assert property (p_sref_hold) else $error("sref lost");
  property p_sref_hiz;
    self_refresh |-> !dq_mem_oe;
  endproperty
  a_sref_hiz: assert property (p_sref_hiz) else $error("dq in sref");
  property p_sref_exit;
    self_refresh && cke |=> !self_refresh;
  endproperty
  a_sref_exit: assert property (p_sref_exit) else $error("sref stuck");
  property p_pdn;
    $fell(cke) && (cs_n || cmd_w == SBP_C_NOP) && all_banks_idle
      |=> power_down;
  endproperty
  a_pdn: assert property (p_pdn) else $error("no power down");
  property p_pdn_exit;
    power_down && cke |=> !power_down;
  endproperty
  a_pdn_exit: assert property (p_pdn_exit) else $error("pdn stuck");
  property p_mrs;
    mrs_w |=> !all_banks_idle ##[1:4] all_banks_idle;
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode set wait wrong");
endmodule

// ---- verif/sdram_bank_power_control_tb.sv ----
// testbench: both ends joined, user side driven and checked
module sdram_bank_power_control_tb
  import sbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  mclk;
  logic                  sys_rst;
  logic                  req_valid;
  logic [2:0]            req_cmd;
  logic [SBP_BA_W-1:0]   req_ba;
  logic [SBP_ADDR_W-1:0] req_addr;
  logic [SBP_DQ_W-1:0]   req_wdata;
  logic [SBP_DQM_W-1:0]  req_dqm;
  logic                  req_cke;
  logic                  req_ready;
  logic [SBP_DQ_W-1:0]   rd_data;
  logic                  all_banks_idle;
  logic                  self_refresh;
  logic                  power_down;
  int                    bad_count;
  int                    compares;
  logic [31:0]           row_d [4] = '{32'h1a2b_3c4d, 32'h5e6f_7081,
                                       32'h92a3_b4c5, 32'hd6e7_f809};
  logic [3:0]            row_ap = 4'ha;
  // ****************************************************************
  // ends and checker
  // ****************************************************************
  sbp_if sbp_if_i ();
  sbp_mem sbp_mem_i (.mclk(mclk), .sys_rst(sys_rst), .pins(sbp_if_i.mem),
    .all_banks_idle(all_banks_idle), .self_refresh(self_refresh),
    .power_down(power_down));
  sbp_ctl sbp_ctl_i (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_dqm(req_dqm), .req_cke(req_cke),
    .req_ready(req_ready), .rd_data(rd_data), .pins(sbp_if_i.ctl));
  sbp_props sbp_props_i (.mclk(mclk), .sys_rst(sys_rst),
    .cke(sbp_if_i.cke), .cs_n(sbp_if_i.cs_n), .ras_n(sbp_if_i.ras_n),
    .cas_n(sbp_if_i.cas_n), .we_n(sbp_if_i.we_n), .ba(sbp_if_i.ba),
    .addr(sbp_if_i.addr), .dq_mem_oe(sbp_if_i.dq_mem_oe),
    .dq_ctl_oe(sbp_if_i.dq_ctl_oe), .all_banks_idle(all_banks_idle),
    .self_refresh(self_refresh), .power_down(power_down));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic cmd(input logic [2:0] c, input logic [1:0] b,
                     input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] m, input logic k);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_ba    <= b;
    req_addr  <= a;
    req_wdata <= d;
    req_dqm   <= m;
    req_cke   <= k;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    if (n >= 20)
      chk("req_ready", 32'h1, 32'(req_ready));
  endtask
  task automatic idle(input int n);
    req_valid <= 1'b0;
    req_cmd   <= SBP_C_NOP;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rst();
    sys_rst   <= 1'b1;
    req_valid <= 1'b0;
    req_cke   <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    idle(1);
    chk("cke", 32'h1, 32'(sbp_if_i.cke));
    chk("cs_n", 32'h1, 32'(sbp_if_i.cs_n));
    chk("dq_mem_oe", 32'h0, 32'(sbp_if_i.dq_mem_oe));
    chk("all_banks_idle", 32'h1, 32'(all_banks_idle));
  endtask
  // ****************************************************************
  // clock, watchdog, sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (4000) @(posedge mclk);
    bad_count++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = SBP_C_NOP;
    req_ba = 2'h0;
    req_addr = 12'h000;
    req_wdata = 32'h0;
    req_dqm = 4'h0;
    req_cke = 1'b1;
    bad_count = 0;
    compares = 0;
    rst();
    for (int i = 0; i < 4; i++) begin
      cmd(SBP_C_ACT, i[1:0], 12'h005, 32'h0, 4'h0, 1'b1);
      cmd(SBP_C_WRITE, i[1:0], {1'b0, row_ap[i], 10'h000}, row_d[i], 4'h0,
          1'b1);
      idle(7);
      chk("all_banks_idle", 32'(row_ap[i]), 32'(all_banks_idle));
      if (!row_ap[i]) begin
        cmd(SBP_C_PRE, i[1:0], 12'h000, 32'h0, 4'h0, 1'b1);
        idle(3);
      end
      chk("all_banks_idle", 32'h1, 32'(all_banks_idle));
    end
    for (int i = 0; i < 4; i++) begin
      cmd(SBP_C_ACT, i[1:0], 12'h005, 32'h0, 4'h0, 1'b1);
      cmd(SBP_C_READ, i[1:0], 12'h000, 32'h0, 4'h0, 1'b1);
      idle(4);
      chk("rd_data", row_d[i], rd_data);
      idle(3);
      cmd(SBP_C_PRE, 2'h3, 12'h400, 32'h0, 4'h0, 1'b1);
      idle(3);
      chk("all_banks_idle", 32'h1, 32'(all_banks_idle));
    end
    cmd(SBP_C_ACT, 2'h0, 12'h005, 32'h0, 4'h0, 1'b1);
    cmd(SBP_C_ACT, 2'h1, 12'h005, 32'h0, 4'h0, 1'b1);
    cmd(SBP_C_PRE, 2'h0, 12'h000, 32'h0, 4'h0, 1'b1);
    idle(3);
    chk("all_banks_idle", 32'h0, 32'(all_banks_idle));
    cmd(SBP_C_PRE, 2'h2, 12'h400, 32'h0, 4'h0, 1'b1);
    idle(3);
    chk("all_banks_idle", 32'h1, 32'(all_banks_idle));
    for (int j = 0; j < 2; j++) begin
      cmd(SBP_C_ACT, 2'h2, 12'h005, 32'h0, 4'h0, 1'b1);
      cmd(SBP_C_READ, 2'h2, 12'h000, 32'h0, 4'h0, 1'b1);
      cmd(j ? SBP_C_STOP : SBP_C_PRE, 2'h2, 12'h000, 32'h0, 4'h0, 1'b1);
      idle(2);
      chk("rd_data", row_d[2], rd_data);
      idle(3);
      cmd(SBP_C_PRE, 2'h2, 12'h400, 32'h0, 4'h0, 1'b1);
      idle(3);
    end
    cmd(SBP_C_ACT, 2'h1, 12'h005, 32'h0, 4'h0, 1'b1);
    cmd(SBP_C_WRITE, 2'h1, 12'h000, 32'h5a5a_0001, 4'h0, 1'b1);
    cmd(SBP_C_PRE, 2'h1, 12'h000, 32'ha5a5_0002, 4'hf, 1'b1);
    idle(3);
    cmd(SBP_C_ACT, 2'h1, 12'h005, 32'h0, 4'h0, 1'b1);
    cmd(SBP_C_READ, 2'h1, 12'h000, 32'h0, 4'h0, 1'b1);
    idle(4);
    chk("rd_data", 32'h5a5a_0001, rd_data);
    idle(3);
    cmd(SBP_C_PRE, 2'h1, 12'h400, 32'h0, 4'h0, 1'b1);
    idle(3);
    cmd(SBP_C_MRS, 2'h0, SBP_MR_RST, 32'h0, 4'h0, 1'b1);
    idle(1);
    chk("all_banks_idle", 32'h0, 32'(all_banks_idle));
    idle(4);
    chk("all_banks_idle", 32'h1, 32'(all_banks_idle));
    cmd(SBP_C_NOP, 2'h0, 12'h000, 32'h0, 4'h0, 1'b0);
    cmd(SBP_C_NOP, 2'h0, 12'h000, 32'h0, 4'h0, 1'b0);
    #1;
    chk("power_down", 32'h1, 32'(power_down));
    cmd(SBP_C_NOP, 2'h0, 12'h000, 32'h0, 4'h0, 1'b1);
    idle(2);
    chk("power_down", 32'h0, 32'(power_down));
    cmd(SBP_C_REF, 2'h0, 12'h000, 32'h0, 4'h0, 1'b0);
    cmd(SBP_C_NOP, 2'h0, 12'h000, 32'h0, 4'h0, 1'b0);
    cmd(SBP_C_NOP, 2'h0, 12'h000, 32'h0, 4'h0, 1'b0);
    #1;
    chk("self_refresh", 32'h1, 32'(self_refresh));
    cmd(SBP_C_NOP, 2'h0, 12'h000, 32'h0, 4'h0, 1'b1);
    idle(3);
    chk("self_refresh", 32'h0, 32'(self_refresh));
    idle(3);
    cmd(SBP_C_ACT, 2'h0, 12'h005, 32'h0, 4'h0, 1'b1);
    cmd(SBP_C_NOP, 2'h0, 12'h000, 32'h0, 4'h0, 1'b0);
    idle(1);
    chk("power_down", 32'h0, 32'(power_down));
    cmd(SBP_C_NOP, 2'h0, 12'h000, 32'h0, 4'h0, 1'b1);
    cmd(SBP_C_PRE, 2'h0, 12'h400, 32'h0, 4'h0, 1'b1);
    idle(3);
    chk("all_banks_idle", 32'h1, 32'(all_banks_idle));
    rst();
    conclude();
  end
endmodule
